// ### verilog/apg_regs.sv
// Purpose: Record-path amplifier gain/mute and auxiliary mic mix registers
// Assumes: Register port strobes are synchronous to clk, at most one read and one write a cycle
// Notes:   Decoded controls change on the same edge that stores a write
//
// Summary of operation
// R1: Left amplifier muted while its top bit set
// R2: Right amplifier mute bit, resets muted
// R3: Left gain linear, half-decibel steps from zero
// R4: Gain codes from 119 upward saturate
// R5: Right gain decodes exactly like left gain
// R6: Left mixer nibbles: input a high, b low
// R7: Valid code auto-connects input a left
// R8: Codes 0 to 8 give 1.5 dB steps
// R9: Software never writes codes 9 to 14
// R10: Code 1111 disconnects input a from left
// R11: Input b to left: valid connects, 1111 disconnects
// R12: Input a to right: valid connects, 1111 disconnects
// R13: Input b to right auto-connects when valid
// R14: Input b right disconnects on 1111; resets 1111
// R15: Reads return written values; controls update immediately

`timescale 1ns/1ps

module apg_regs
  import apg_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wr_data,
  output logic      [7:0]        reg_rd_data,
  output logic                   reg_rd_valid,
  // Amplifier controls
  output apg_pga_ctrl_s          left_pga,
  output apg_pga_ctrl_s          right_pga,
  // Mixer path controls
  output apg_mix_path_s          left_mix_input_a,
  output apg_mix_path_s          left_mix_input_b,
  output apg_mix_path_s          right_mix_input_a,
  output apg_mix_path_s          right_mix_input_b
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Refused at elaboration: narrower buses alias the four offsets
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_w_check
    $error("apg_regs: ADDR_W must be 5 to 8 to reach registers 0x0F-0x12");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] sat_gain(input logic [6:0] code);
    sat_gain = (code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code;
  endfunction : sat_gain

  function automatic apg_pga_ctrl_s pga_decode(input logic [7:0] value);
    pga_decode.mute         = value[MUTE_BIT];
    pga_decode.gain_half_db = sat_gain(value[GAIN_MSB:0]);
  endfunction : pga_decode

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic sel_left_gain  = (reg_addr == ADDR_W'(ADDR_LEFT_ADC_AMP_GAIN));
  wire logic sel_right_gain = (reg_addr == ADDR_W'(ADDR_RIGHT_ADC_AMP_GAIN));
  wire logic sel_left_mix   = (reg_addr == ADDR_W'(ADDR_AUX_MIC_TO_LEFT_MIXER));
  wire logic sel_right_mix  = (reg_addr == ADDR_W'(ADDR_AUX_MIC_TO_RIGHT_MIXER));

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] left_gain_q;
  logic [7:0] right_gain_q;
  logic [7:0] left_mix_q;
  logic [7:0] right_mix_q;

  wire logic [7:0] left_gain_d  = (reg_wr_en && sel_left_gain)  ? reg_wr_data : left_gain_q;
  wire logic [7:0] right_gain_d = (reg_wr_en && sel_right_gain) ? reg_wr_data : right_gain_q;
  wire logic [7:0] left_mix_d   = (reg_wr_en && sel_left_mix)   ? reg_wr_data : left_mix_q;
  wire logic [7:0] right_mix_d  = (reg_wr_en && sel_right_mix)  ? reg_wr_data : right_mix_q;

  // Mute bits reset set so both amplifiers start silent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_gain_q  <= RST_ADC_AMP_GAIN;  // [R1] [R3]
      right_gain_q <= RST_ADC_AMP_GAIN;  // [R2] [R5]
      left_mix_q   <= RST_AUX_MIC_MIX;   // [R6]
      right_mix_q  <= RST_AUX_MIC_MIX;   // [R14]
    end else begin
      left_gain_q  <= left_gain_d;       // [R15]
      right_gain_q <= right_gain_d;
      left_mix_q   <= left_mix_d;
      right_mix_q  <= right_mix_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero; a read in a write cycle sees the old value
  wire logic [7:0] rd_mux =
    sel_left_gain  ? left_gain_q  :
    sel_right_gain ? right_gain_q :
    sel_left_mix   ? left_mix_q   :
    sel_right_mix  ? right_mix_q  : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      reg_rd_data  <= reg_rd_en ? rd_mux : reg_rd_data;  // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Mixer level decode
  // ----------------------------------------------------------------
  // Decoding the next value lets controls follow the write on the same edge
  apg_mix_path_s lma_d;
  apg_mix_path_s lmb_d;
  apg_mix_path_s rma_d;
  apg_mix_path_s rmb_d;

  apg_level_decode u_dec_lma (  // [R7] [R8] [R10]
    .level_code (left_mix_d[INPUT_A_MSB:INPUT_A_LSB]),
    .path       (lma_d)
  );
  apg_level_decode u_dec_lmb (  // [R11]
    .level_code (left_mix_d[INPUT_B_MSB:INPUT_B_LSB]),
    .path       (lmb_d)
  );
  apg_level_decode u_dec_rma (  // [R12]
    .level_code (right_mix_d[INPUT_A_MSB:INPUT_A_LSB]),
    .path       (rma_d)
  );
  apg_level_decode u_dec_rmb (  // [R13] [R14]
    .level_code (right_mix_d[INPUT_B_MSB:INPUT_B_LSB]),
    .path       (rmb_d)
  );

  // ----------------------------------------------------------------
  // Registered controls
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_pga          <= '{mute: 1'b1, gain_half_db: 7'h00};
      right_pga         <= '{mute: 1'b1, gain_half_db: 7'h00};
      left_mix_input_a  <= '{connect: 1'b0, atten_steps: 4'h0};
      left_mix_input_b  <= '{connect: 1'b0, atten_steps: 4'h0};
      right_mix_input_a <= '{connect: 1'b0, atten_steps: 4'h0};
      right_mix_input_b <= '{connect: 1'b0, atten_steps: 4'h0};
    end else begin
      left_pga          <= pga_decode(left_gain_d);   // [R1] [R3] [R4]
      right_pga         <= pga_decode(right_gain_d);  // [R2] [R5]
      left_mix_input_a  <= lma_d;
      left_mix_input_b  <= lmb_d;
      right_mix_input_a <= rma_d;
      right_mix_input_b <= rmb_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_left_mute_follows_write;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr_en && sel_left_gain) |=> (left_pga.mute == $past(reg_wr_data[MUTE_BIT]));
  endproperty
  a_left_mute_follows_write: assert property (p_left_mute_follows_write)  // [R1]
    else $error("left mute did not follow write");

  property p_mute_after_reset;
    @(posedge clk)
    $past(sys_rst) && !sys_rst |-> left_pga.mute && right_pga.mute
                                   && left_gain_q == RST_ADC_AMP_GAIN
                                   && right_gain_q == RST_ADC_AMP_GAIN;
  endproperty
  a_mute_after_reset: assert property (p_mute_after_reset)  // [R2]
    else $error("amplifiers not muted after reset");

  property p_right_mute_level;
    @(posedge clk) disable iff (sys_rst)
    right_pga.mute == right_gain_q[MUTE_BIT];
  endproperty
  a_right_mute_level: assert property (p_right_mute_level)  // [R2]
    else $error("right mute differs from register bit");

  property p_left_gain_linear;
    @(posedge clk) disable iff (sys_rst)
    (left_gain_q[6:0] <= 7'h76) |-> (left_pga.gain_half_db == left_gain_q[6:0]);
  endproperty
  a_left_gain_linear: assert property (p_left_gain_linear)  // [R3]
    else $error("left gain not linear below ceiling");

  property p_gain_saturates;
    @(posedge clk) disable iff (sys_rst)
    (left_gain_q[6:0] >= 7'h77) |-> (left_pga.gain_half_db == 7'h77);
  endproperty
  a_gain_saturates: assert property (p_gain_saturates)  // [R4]
    else $error("left gain did not saturate at 59.5 dB");

  property p_right_gain_same;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr_en && sel_right_gain) |=> (right_pga.gain_half_db ==
      (($past(reg_wr_data[6:0]) > GAIN_CODE_MAX) ? GAIN_CODE_MAX : $past(reg_wr_data[6:0])));
  endproperty
  a_right_gain_same: assert property (p_right_gain_same)  // [R5]
    else $error("right gain decode differs from left");

  property p_left_a_connects;
    @(posedge clk) disable iff (sys_rst)
    (reg_wr_en && sel_left_mix && reg_wr_data[7:4] <= 4'h8)
      |=> left_mix_input_a.connect && left_mix_input_a.atten_steps == $past(reg_wr_data[7:4]);
  endproperty
  a_left_a_connects: assert property (p_left_a_connects)  // [R7]
    else $error("input a not connected to left mixer");

  property p_left_a_off;
    @(posedge clk) disable iff (sys_rst)
    (left_mix_q[7:4] == 4'hF) |-> !left_mix_input_a.connect;
  endproperty
  a_left_a_off: assert property (p_left_a_off)  // [R10]
    else $error("input a left not disconnected by 1111");

  property p_left_b_path;
    @(posedge clk) disable iff (sys_rst)
    left_mix_input_b.connect == (left_mix_q[3:0] <= 4'h8);
  endproperty
  a_left_b_path: assert property (p_left_b_path)  // [R11]
    else $error("input b left connect wrong");

  property p_right_paths;
    @(posedge clk) disable iff (sys_rst)
    (right_mix_input_a.connect == (right_mix_q[7:4] <= 4'h8))
      && (right_mix_input_b.connect == (right_mix_q[3:0] <= 4'h8));
  endproperty
  a_right_paths: assert property (p_right_paths)  // [R12] [R13] [R14]
    else $error("right mixer connect wrong");

  property p_readback;
    @(posedge clk) disable iff (sys_rst)
    (reg_rd_en && sel_left_mix) |=> reg_rd_valid && reg_rd_data == $past(left_mix_q);
  endproperty
  a_readback: assert property (p_readback)  // [R15]
    else $error("readback differs from stored value");

endmodule : apg_regs

// ### pkg/apg_pkg.sv
// Purpose: Shared constants and types for the record-path gain and mix registers
// Assumes: Registers are addressed by their page-0 register number
// Notes:   Gain is carried in half-decibel units, mix attenuation in 1.5 dB units

package apg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LEFT_ADC_AMP_GAIN      = 8'h0F;
  localparam logic [7:0] ADDR_RIGHT_ADC_AMP_GAIN     = 8'h10;
  localparam logic [7:0] ADDR_AUX_MIC_TO_LEFT_MIXER  = 8'h11;
  localparam logic [7:0] ADDR_AUX_MIC_TO_RIGHT_MIXER = 8'h12;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ADC_AMP_GAIN = 8'h80;
  localparam logic [7:0] RST_AUX_MIC_MIX  = 8'hFF;
  localparam int         MUTE_BIT         = 7;
  localparam int         GAIN_MSB         = 6;
  localparam int         INPUT_A_MSB      = 7;
  localparam int         INPUT_A_LSB      = 4;
  localparam int         INPUT_B_MSB      = 3;
  localparam int         INPUT_B_LSB      = 0;

  // ----------------------------------------------------------------
  // Code limits
  // ----------------------------------------------------------------
  // Highest distinct gain code, 59.5 dB in half-decibel steps
  localparam logic [6:0] GAIN_CODE_MAX    = 7'h77;
  // Highest valid attenuation code, -12 dB
  localparam logic [3:0] LEVEL_CODE_MAX   = 4'h8;
  localparam logic [3:0] LEVEL_CODE_OFF   = 4'hF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       mute;
    logic [6:0] gain_half_db;
  } apg_pga_ctrl_s;

  typedef struct packed {
    logic       connect;
    logic [3:0] atten_steps;
  } apg_mix_path_s;

endpackage : apg_pkg

// ### verilog/apg_level_decode.sv
// Purpose: Decode one four-bit input level code into connect and attenuation
// Assumes: Codes 9 to 14 are never written by software
// Notes:   Purely combinational; the caller registers the result

`timescale 1ns/1ps

module apg_level_decode
  import apg_pkg::*;
(
  // Level code
  input  wire logic [3:0]    level_code,
  // Decoded path control
  output apg_mix_path_s      path
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Reserved codes fall out as disconnected: a silent input is safer than noise
  wire logic code_valid = (level_code <= LEVEL_CODE_MAX);

  assign path.connect     = code_valid;
  assign path.atten_steps = code_valid ? level_code : 4'h0;

endmodule : apg_level_decode

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the record-path gain and mix registers
// Assumes: Strobe port as handed over; read answer registered on the taking edge, valid for one cycle
// Notes:   Reference copy of the four registers lives in mdl; reserved codes never written

`timescale 1ns/1ps

module tb_top
  import apg_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          clk         = 1'b0;
  logic          sys_rst     = 1'b1;
  logic          reg_wr_en   = 1'b0;
  logic          reg_rd_en   = 1'b0;
  logic [7:0]    reg_addr    = 8'h00;
  logic [7:0]    reg_wr_data = 8'h00;
  logic [7:0]    reg_rd_data;
  logic          reg_rd_valid;
  apg_pga_ctrl_s left_pga;
  apg_pga_ctrl_s right_pga;
  apg_mix_path_s left_mix_input_a;
  apg_mix_path_s left_mix_input_b;
  apg_mix_path_s right_mix_input_a;
  apg_mix_path_s right_mix_input_b;
  logic [7:0]    addrs [4];
  logic [7:0]    mdl   [4];
  int            n_mismatch = 0;
  int            tests_run  = 0;

  apg_regs #(.ADDR_W(8)) i_apg_regs (
    .clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .left_pga(left_pga), .right_pga(right_pga),
    .left_mix_input_a(left_mix_input_a), .left_mix_input_b(left_mix_input_b),
    .right_mix_input_a(right_mix_input_a), .right_mix_input_b(right_mix_input_b));

  initial begin
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic apg_pga_ctrl_s pga_exp(input logic [7:0] r);
    apg_pga_ctrl_s p;
    p.mute         = r[7];
    p.gain_half_db = (r[6:0] > GAIN_CODE_MAX) ? GAIN_CODE_MAX : r[6:0];
    return p;
  endfunction : pga_exp

  // Reserved codes decode as disconnected, same as code 1111
  function automatic logic [7:0] mix_exp(input logic [3:0] c);
    return (c <= 4'h8) ? {3'h0, 1'b1, c} : 8'h00;
  endfunction : mix_exp

  task automatic cmp(input string name, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : cmp

  task automatic check_all();
    cmp("left_pga", pga_exp(mdl[0]), left_pga);
    cmp("right_pga", pga_exp(mdl[1]), right_pga);
    cmp("left_mix_input_a", mix_exp(mdl[2][7:4]), {3'h0, left_mix_input_a});
    cmp("left_mix_input_b", mix_exp(mdl[2][3:0]), {3'h0, left_mix_input_b});
    cmp("right_mix_input_a", mix_exp(mdl[3][7:4]), {3'h0, right_mix_input_a});
    cmp("right_mix_input_b", mix_exp(mdl[3][3:0]), {3'h0, right_mix_input_b});
  endtask : check_all

  task automatic model_reset();
    mdl = '{RST_ADC_AMP_GAIN, RST_ADC_AMP_GAIN, RST_AUX_MIC_MIX, RST_AUX_MIC_MIX};
  endtask : model_reset

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (addrs[i] == a) mdl[i] = d;
    end
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    cmp("reg_rd_valid", 8'h01, {7'h0, reg_rd_valid});
    cmp("reg_rd_data", e, reg_rd_data);
    @(posedge clk);
    #1;
    cmp("reg_rd_valid_drop", 8'h00, {7'h0, reg_rd_valid});
  endtask : rd

  task automatic rd_all();
    for (int i = 0; i < 4; i++) rd(addrs[i], mdl[i]);
  endtask : rd_all

  // Only codes 0..8 and 1111 reach a level nibble
  function automatic logic [3:0] rand_level();
    int r;
    r = $urandom_range(0, 9);
    return (r == 9) ? 4'hF : 4'(r);
  endfunction : rand_level

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] g [6];
    int k;
    addrs = '{ADDR_LEFT_ADC_AMP_GAIN, ADDR_RIGHT_ADC_AMP_GAIN,
              ADDR_AUX_MIC_TO_LEFT_MIXER, ADDR_AUX_MIC_TO_RIGHT_MIXER};
    g = '{8'h00, 8'h01, 8'h76, 8'h77, 8'h78, 8'h7F};
    void'($urandom(32'hF9E73FAA));
    model_reset();
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check_all();
    cmp("reg_rd_data_init", 8'h00, reg_rd_data);
    cmp("reg_rd_valid_init", 8'h00, {7'h0, reg_rd_valid});
    rd_all();
    for (int i = 0; i < 6; i++) begin
      wr(addrs[0], {i[0], g[i][6:0]});
      check_all();
      wr(addrs[1], {~i[0], g[5 - i][6:0]});
      check_all();
    end
    for (int c = 0; c <= 9; c++) begin
      k = (c == 9) ? 15 : c;
      wr(addrs[2], {4'(k), (k == 15) ? 4'hF : 4'(8 - k)});
      check_all();
      wr(addrs[3], {(k == 15) ? 4'h0 : 4'(8 - k), 4'(k)});
      check_all();
    end
    wr(8'h13, 8'h00);
    wr(8'h0E, 8'h00);
    check_all();
    rd(8'h13, 8'h00);
    rd_all();
    // Read and write taken on one edge: the read returns the old value
    @(posedge clk);
    reg_wr_en   <= 1'b1;
    reg_rd_en   <= 1'b1;
    reg_addr    <= addrs[0];
    reg_wr_data <= 8'h2A;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    #1;
    cmp("reg_rd_data_old", mdl[0], reg_rd_data);
    mdl[0] = 8'h2A;
    check_all();
    for (int n = 0; n < 150; n++) begin
      k = $urandom_range(0, 3);
      if (k < 2) wr(addrs[k], 8'($urandom()));
      else wr(addrs[k], {rand_level(), rand_level()});
      check_all();
      if ($urandom_range(0, 3) == 0) begin
        k = $urandom_range(0, 3);
        rd(addrs[k], mdl[k]);
      end
    end
    // Leave a nonzero read value behind so the reset clear is visible
    wr(addrs[0], 8'h5A);
    rd(addrs[0], mdl[0]);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    model_reset();
    #1;
    check_all();
    cmp("reg_rd_data_rst", 8'h00, reg_rd_data);
    cmp("reg_rd_valid_rst", 8'h00, {7'h0, reg_rd_valid});
    rd_all();
    wrap_up();
  end

  initial begin
    #(40 * 6000);
    n_mismatch++;
    wrap_up();
  end

endmodule : tb_top
